// ### src/rco_params.svh
// constants for the reset-cause and rc oscillator control block
// Functional notes
// R1 - low-power reset sets bit 31, sticky
// R2 - window watchdog reset sets bit 30, sticky
// R3 - independent watchdog reset sets bit 29, sticky
// R4 - software reset sets bit 28, sticky
// R5 - power-on/down reset sets bit 27, sticky
// R6 - external reset pin sets bit 26
// R7 - memory-management reset sets bit 25, sticky
// R8 - ram reset sets bit 23, sticky
// R9 - writing one to bit 24 clears flags
// R10 - calibration word is trim plus factory value
// R11 - factory calibration loaded at power-on, read-only
// R12 - range code decodes seven frequencies, default 4MHz
// R13 - multispeed ready rises stable, falls six edges
// R14 - multispeed enable clear refused while system clock
// R15 - wake or external oscillator fail forces enable
// R16 - lowspeed ready falls three edges after disable
// R17 - lowspeed enable bit runs the 40kHz oscillator
// R18 - flags survive system resets, power-on loads por and pin flags set
`ifndef RCO_PARAMS_SVH
`define RCO_PARAMS_SVH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define RCO_ADDR_W          8
`define RCO_CTRLSTS_OFF     8'h24
`define RCO_IRQ_STAT_OFF    8'h40
`define RCO_IRQ_MASK_OFF    8'h44

// ---------------------------------------------------------------
// clock_control_status field positions
// ---------------------------------------------------------------
`define RCO_FLAGS_HI_MSB    31
`define RCO_FLAGS_HI_LSB    25
`define RCO_CLEAR_BIT       24
`define RCO_RAM_FLAG_BIT    23
`define RCO_TRIM_MSB        22
`define RCO_TRIM_LSB        15
`define RCO_CAL_MSB         14
`define RCO_CAL_LSB         7
`define RCO_RANGE_MSB       6
`define RCO_RANGE_LSB       4
`define RCO_MSI_RDY_BIT     3
`define RCO_MSI_EN_BIT      2
`define RCO_LSI_RDY_BIT     1
`define RCO_LSI_EN_BIT      0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RCO_CTRLSTS_RST     32'h0C00246C
`define RCO_FLAGS_RST       8'h0C
`define RCO_TRIM_RST        8'h00
`define RCO_CAL_RST         8'h48
`define RCO_RANGE_RST       3'h6
`define RCO_RANGE_BAD       3'h7
`define RCO_MSI_EN_RST      1'b1
`define RCO_MSI_RDY_RST     1'b1
`define RCO_LSI_EN_RST      1'b0
`define RCO_IRQ_MASK_RST    4'h0

// ---------------------------------------------------------------
// timing counts, in oscillator edges and system clocks
// ---------------------------------------------------------------
`define RCO_MSI_OFF_EDGES   3'd6
`define RCO_LSI_OFF_EDGES   3'd3
`define RCO_CAL_LOAD_CYC    2'd2

// ---------------------------------------------------------------
// interrupt event bits
// ---------------------------------------------------------------
`define RCO_EV_MSI_RDY      0
`define RCO_EV_LSI_RDY      1
`define RCO_EV_MSI_FORCED   2
`define RCO_EV_MSI_REFUSED  3

`endif

// ### src/rco_pkg.sv
// types shared by the reset-cause and rc oscillator control block
`include "rco_params.svh"
package rco_pkg;

	// index of each synchronised asynchronous input
	typedef enum int {
		RCO_IN_LPWR, RCO_IN_WWDG, RCO_IN_IWDG, RCO_IN_SFT,
		RCO_IN_POR, RCO_IN_PIN, RCO_IN_MMU, RCO_IN_RAM,
		RCO_IN_MSI_STABLE, RCO_IN_MSI_CLK, RCO_IN_LSI_STABLE, RCO_IN_LSI_CLK,
		RCO_IN_SYSCLK, RCO_IN_WAKE_STOP, RCO_IN_WAKE_STBY, RCO_IN_HSE_FAIL,
		RCO_IN_COUNT
	} rco_in_t;

	// whole state of the block, registered by one process
	typedef struct packed {
		logic [15:0] sync1;
		logic [15:0] sync2;
		logic [7:0]  flags;        // lpwr,wwdg,iwdg,sft,por,pin,mmu,ram
		logic [7:0]  trim;
		logic [7:0]  cal;
		logic [7:0]  cal_sync1;
		logic [7:0]  cal_sync2;
		logic [1:0]  cal_cnt;
		logic        cal_loaded;
		logic [2:0]  range;
		logic        msi_en;
		logic        msi_rdy;
		logic [2:0]  msi_cnt;
		logic        msi_clk_prev;
		logic        lsi_en;
		logic        lsi_rdy;
		logic [2:0]  lsi_cnt;
		logic        lsi_clk_prev;
		logic [7:0]  cal_word;
		logic [12:0] freq_khz;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		logic        irq;
		logic        ack;
		logic [31:0] rdata;
	} rco_state_t;

endpackage : rco_pkg

// ### src/rco_ctrl.sv
// reset-cause flags and rc oscillator control, wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "rco_params.svh"

module rco_ctrl
	import rco_pkg::*;
(
	// clock and power-on reset
	input  wire logic        clk,
	input  wire logic        reset,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	// reset cause indications from the reset controller
	input  wire logic        lowpower_mgmt_reset_evt,
	input  wire logic        windowed_watchdog_reset_evt,
	input  wire logic        independent_watchdog_reset_evt,
	input  wire logic        software_reset_evt,
	input  wire logic        power_on_reset_evt,
	input  wire logic        external_reset_pin_evt,
	input  wire logic        memory_mgmt_reset_evt,
	input  wire logic        ram_reset_evt,
	// multispeed rc oscillator
	input  wire logic        multispeed_osc_stable,
	input  wire logic        multispeed_osc_clk,
	input  wire logic [7:0]  multispeed_osc_factory_cal_in,
	output var  logic        multispeed_osc_enable_out,
	output var  logic [7:0]  multispeed_osc_cal_word,
	output var  logic [2:0]  multispeed_osc_range_out,
	output var  logic [12:0] multispeed_osc_freq_khz,
	// lowspeed rc oscillator
	input  wire logic        lowspeed_rc_stable,
	input  wire logic        lowspeed_rc_clk,
	output var  logic        lowspeed_rc_enable_out,
	// system conditions that steer the multispeed enable
	input  wire logic        multispeed_is_sysclk,
	input  wire logic        wake_from_deepest_stop_mode,
	input  wire logic        wake_from_standby,
	input  wire logic        external_highspeed_osc_fail,
	// interrupt
	output var  logic        irq
);

	// ---------------------------------------------------------------
	// state and next state
	// ---------------------------------------------------------------
	rco_state_t st_reg;
	rco_state_t st_next;

	logic [15:0] async_in;
	logic [15:0] s;            // synchronised inputs
	logic        req;
	logic        wr;
	logic        msi_edge;
	logic        lsi_edge;
	logic [7:0]  flag_set;
	logic        clr_flags;
	logic        forced_on;

	// gather asynchronous inputs in the order of rco_in_t
	assign async_in = {external_highspeed_osc_fail, wake_from_standby,
	                   wake_from_deepest_stop_mode, multispeed_is_sysclk,
	                   lowspeed_rc_clk, lowspeed_rc_stable,
	                   multispeed_osc_clk, multispeed_osc_stable,
	                   ram_reset_evt, memory_mgmt_reset_evt,
	                   external_reset_pin_evt, power_on_reset_evt,
	                   software_reset_evt, independent_watchdog_reset_evt,
	                   windowed_watchdog_reset_evt, lowpower_mgmt_reset_evt};

	// only the second synchroniser stage is ever looked at
	assign s = st_reg.sync2;

	// edges of the slow oscillator clocks, seen through the synchronisers;
	// both run far below half of clk so no edge can be missed
	assign msi_edge = s[RCO_IN_MSI_CLK] & ~st_reg.msi_clk_prev;
	assign lsi_edge = s[RCO_IN_LSI_CLK] & ~st_reg.lsi_clk_prev;

	// one request per bus cycle; ack drops the cycle after it is given
	assign req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
	assign wr  = req & wb_we_i;

	// reset causes as levels, in the bit order of the flags field
	// a cause held for several cycles simply sets its flag again each cycle
	assign flag_set = {s[RCO_IN_LPWR], s[RCO_IN_WWDG], s[RCO_IN_IWDG],  // see R1 see R2 see R3
	                   s[RCO_IN_SFT], s[RCO_IN_POR], s[RCO_IN_PIN],     // see R4 see R5 see R6
	                   s[RCO_IN_MMU], s[RCO_IN_RAM]};                   // see R7 see R8

	assign clr_flags = wr & (wb_adr_i == `RCO_CTRLSTS_OFF) & wb_sel_i[3]
	                   & wb_dat_i[`RCO_CLEAR_BIT];

	assign forced_on = s[RCO_IN_WAKE_STOP] | s[RCO_IN_WAKE_STBY] | s[RCO_IN_HSE_FAIL];

	// ---------------------------------------------------------------
	// range decode to kHz; code 7 never reaches the register
	// ---------------------------------------------------------------
	function automatic logic [12:0] rco_freq(input logic [2:0] r);
		case (r)
			3'h0:    rco_freq = 13'd100;
			3'h1:    rco_freq = 13'd200;
			3'h2:    rco_freq = 13'd400;
			3'h3:    rco_freq = 13'd800;
			3'h4:    rco_freq = 13'd1000;
			3'h5:    rco_freq = 13'd2000;
			3'h6:    rco_freq = 13'd4000;
			default: rco_freq = 13'd4000;
		endcase
	endfunction : rco_freq

	// read view of a register at a given address
	function automatic logic [31:0] rco_read(input rco_state_t q, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0;
		case (a)
			`RCO_CTRLSTS_OFF: begin
				d[`RCO_FLAGS_HI_MSB:`RCO_FLAGS_HI_LSB] = q.flags[7:1];
				d[`RCO_RAM_FLAG_BIT]                   = q.flags[0];
				d[`RCO_TRIM_MSB:`RCO_TRIM_LSB]         = q.trim;
				d[`RCO_CAL_MSB:`RCO_CAL_LSB]           = q.cal;
				d[`RCO_RANGE_MSB:`RCO_RANGE_LSB]       = q.range;
				d[`RCO_MSI_RDY_BIT]                    = q.msi_rdy;
				d[`RCO_MSI_EN_BIT]                     = q.msi_en;
				d[`RCO_LSI_RDY_BIT]                    = q.lsi_rdy;
				d[`RCO_LSI_EN_BIT]                     = q.lsi_en;
			end
			`RCO_IRQ_STAT_OFF: d[3:0] = q.irq_stat;
			`RCO_IRQ_MASK_OFF: d[3:0] = q.irq_mask;
			default:           d = 32'h0;
		endcase
		rco_read = d;
	endfunction : rco_read

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic [3:0] ev;
		ev = 4'h0;
		st_next = st_reg;

		// two-stage synchronisers, stage one feeds stage two only
		st_next.sync1        = async_in;
		st_next.sync2        = st_reg.sync1;
		st_next.msi_clk_prev = s[RCO_IN_MSI_CLK];
		st_next.lsi_clk_prev = s[RCO_IN_LSI_CLK];

		// factory calibration caught after release, then frozen
		st_next.cal_sync1 = multispeed_osc_factory_cal_in;
		st_next.cal_sync2 = st_reg.cal_sync1;
		if (!st_reg.cal_loaded) begin
			if (st_reg.cal_cnt == `RCO_CAL_LOAD_CYC) begin
				st_next.cal        = st_reg.cal_sync2;  // see R11
				st_next.cal_loaded = 1'b1;
			end else begin
				st_next.cal_cnt = st_reg.cal_cnt + 2'd1;
			end
		end

		// sticky reset flags: a cause present in the clear cycle survives.
		// flags live on the power-on reset only, so system resets keep them
		st_next.flags = (st_reg.flags & ~{8{clr_flags}}) | flag_set;  // see R1 see R9 see R18

		// software fields of clock_control_status, byte lane by lane
		if (wr && wb_adr_i == `RCO_CTRLSTS_OFF) begin
			if (wb_sel_i[2])
				st_next.trim[7:1] = wb_dat_i[`RCO_TRIM_MSB:16];
			if (wb_sel_i[1])
				st_next.trim[0] = wb_dat_i[`RCO_TRIM_LSB];
			if (wb_sel_i[0]) begin
				// reserved code 7 is dropped so the decode stays defined
				if (wb_dat_i[`RCO_RANGE_MSB:`RCO_RANGE_LSB] != `RCO_RANGE_BAD)
					st_next.range = wb_dat_i[`RCO_RANGE_MSB:`RCO_RANGE_LSB];
				st_next.lsi_en = wb_dat_i[`RCO_LSI_EN_BIT];  // see R17
				if (wb_dat_i[`RCO_MSI_EN_BIT]) begin
					st_next.msi_en = 1'b1;
				end else if (s[RCO_IN_SYSCLK]) begin
					ev[`RCO_EV_MSI_REFUSED] = st_reg.msi_en;  // see R14
				end else begin
					st_next.msi_en = 1'b0;
				end
			end
		end

		// hardware start of the multispeed oscillator outranks software
		if (forced_on) begin
			st_next.msi_en = 1'b1;  // see R15
			ev[`RCO_EV_MSI_FORCED] = ~st_reg.msi_en;
		end

		// multispeed ready: up when stable, down on sixth edge after disable
		if (st_reg.msi_en) begin
			st_next.msi_cnt = 3'd0;
			if (s[RCO_IN_MSI_STABLE])
				st_next.msi_rdy = 1'b1;  // see R13
		end else if (st_reg.msi_rdy && msi_edge) begin
			if (st_reg.msi_cnt == `RCO_MSI_OFF_EDGES - 3'd1) begin
				st_next.msi_rdy = 1'b0;  // see R13
				st_next.msi_cnt = 3'd0;
			end else begin
				st_next.msi_cnt = st_reg.msi_cnt + 3'd1;
			end
		end
		ev[`RCO_EV_MSI_RDY] = st_next.msi_rdy & ~st_reg.msi_rdy;

		// lowspeed ready follows the oscillator, three edges to fall
		if (st_reg.lsi_en) begin
			st_next.lsi_cnt = 3'd0;
			if (s[RCO_IN_LSI_STABLE])
				st_next.lsi_rdy = 1'b1;  // see R16
		end else if (st_reg.lsi_rdy && lsi_edge) begin
			if (st_reg.lsi_cnt == `RCO_LSI_OFF_EDGES - 3'd1) begin
				st_next.lsi_rdy = 1'b0;  // see R16
				st_next.lsi_cnt = 3'd0;
			end else begin
				st_next.lsi_cnt = st_reg.lsi_cnt + 3'd1;
			end
		end
		ev[`RCO_EV_LSI_RDY] = st_next.lsi_rdy & ~st_reg.lsi_rdy;

		// oscillator outputs; the sum wraps at eight bits like the trim hardware
		// the cut to eight bits is deliberate: the trim sum wraps
		st_next.cal_word = 8'(st_reg.trim + st_reg.cal);  // see R10
		st_next.freq_khz = rco_freq(st_reg.range);     // see R12

		// interrupt status: write one to clear, a new event wins
		if (wr && wb_adr_i == `RCO_IRQ_STAT_OFF && wb_sel_i[0])
			st_next.irq_stat = st_reg.irq_stat & ~wb_dat_i[3:0];
		st_next.irq_stat = st_next.irq_stat | ev;
		if (wr && wb_adr_i == `RCO_IRQ_MASK_OFF && wb_sel_i[0])
			st_next.irq_mask = wb_dat_i[3:0];
		st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

		// bus answer one cycle after the request, unmapped reads give zero
		st_next.ack   = req;
		st_next.rdata = req ? rco_read(st_reg, wb_adr_i) : 32'h0;
	end

	// ---------------------------------------------------------------
	// state register, power-on reset
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg            <= '0;
			st_reg.flags      <= `RCO_FLAGS_RST;   // see R5
			st_reg.trim       <= `RCO_TRIM_RST;
			st_reg.cal        <= `RCO_CAL_RST;
			st_reg.range      <= `RCO_RANGE_RST;
			st_reg.msi_en     <= `RCO_MSI_EN_RST;
			st_reg.msi_rdy    <= `RCO_MSI_RDY_RST;
			st_reg.lsi_en     <= `RCO_LSI_EN_RST;
			st_reg.cal_word   <= `RCO_TRIM_RST + `RCO_CAL_RST;
			st_reg.freq_khz   <= 13'd4000;
			st_reg.irq_mask   <= `RCO_IRQ_MASK_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from the state register
	// ---------------------------------------------------------------
	assign wb_dat_o                  = st_reg.rdata;
	assign wb_ack_o                  = st_reg.ack;
	assign multispeed_osc_enable_out = st_reg.msi_en;
	assign multispeed_osc_cal_word   = st_reg.cal_word;
	assign multispeed_osc_range_out  = st_reg.range;
	assign multispeed_osc_freq_khz   = st_reg.freq_khz;
	assign lowspeed_rc_enable_out    = st_reg.lsi_en;
	assign irq                       = st_reg.irq;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	flags_sticky_a: assert property (  // see R2 see R3 see R4 see R6 see R7 see R8
		!clr_flags |=> ((st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags)))
		else $error("reset flag lost without clear");

	flag_clear_a: assert property (  // see R9
		clr_flags && flag_set == 8'h0 |=> st_reg.flags == 8'h0)
		else $error("flag clear did not empty flags");

	flag_set_a: assert property (  // see R1
		flag_set[7] |=> st_reg.flags[7])
		else $error("low-power reset flag not set");

	msi_fall_count_a: assert property (  // see R13
		$fell(st_reg.msi_rdy) |-> $past(st_reg.msi_cnt) == 3'd5 && !$past(st_reg.msi_en))
		else $error("multispeed ready fell at wrong edge count");

	lsi_fall_count_a: assert property (  // see R16
		$fell(st_reg.lsi_rdy) |-> $past(st_reg.lsi_cnt) == 3'd2 && !$past(st_reg.lsi_en))
		else $error("lowspeed ready fell at wrong edge count");

	msi_hold_on_a: assert property (  // see R14
		st_reg.msi_en && s[RCO_IN_SYSCLK] |=> st_reg.msi_en)
		else $error("multispeed enable cleared while system clock");

	msi_forced_a: assert property (  // see R15
		forced_on |=> st_reg.msi_en && multispeed_osc_enable_out)
		else $error("multispeed not started by hardware");

	cal_word_a: assert property (  // see R10
		##1 multispeed_osc_cal_word == 8'($past(st_reg.trim) + $past(st_reg.cal)))
		else $error("calibration word is not trim plus factory value");

	cal_frozen_a: assert property (  // see R11
		st_reg.cal_loaded |=> $stable(st_reg.cal))
		else $error("factory calibration changed after load");

	range_decode_a: assert property (  // see R12
		st_reg.range == 3'h6 ##1 st_reg.range == 3'h6 |-> multispeed_osc_freq_khz == 13'd4000)
		else $error("range code 6 not decoded to 4MHz");

	lsi_enable_a: assert property (  // see R17
		wr && wb_adr_i == `RCO_CTRLSTS_OFF && wb_sel_i[0]
		|=> lowspeed_rc_enable_out == $past(wb_dat_i[0]))
		else $error("lowspeed enable not taken from write");

	irq_level_a: assert property (irq == |(st_reg.irq_stat & st_reg.irq_mask))
		else $error("interrupt output does not match masked status");

	// stronger flag check: without a clear, every present cause is added
	// and nothing else changes
	flag_cause_a: assert property (  // see R2 see R3 see R4 see R5 see R6 see R7 see R8
		!clr_flags |=> st_reg.flags == ($past(st_reg.flags) | $past(flag_set)))
		else $error("reset cause did not reach its flag");

	msi_ready_rise_a: assert property (  // see R13
		st_reg.msi_en && s[RCO_IN_MSI_STABLE] |=> st_reg.msi_rdy)
		else $error("multispeed ready not raised when stable");

	lsi_ready_rise_a: assert property (  // see R16
		st_reg.lsi_en && s[RCO_IN_LSI_STABLE] |=> st_reg.lsi_rdy)
		else $error("lowspeed ready not raised when stable");

	msi_clear_taken_a: assert property (  // see R14
		wr && wb_adr_i == `RCO_CTRLSTS_OFF && wb_sel_i[0] && !wb_dat_i[`RCO_MSI_EN_BIT]
		&& !s[RCO_IN_SYSCLK] && !forced_on |=> !multispeed_osc_enable_out)
		else $error("multispeed enable clear not taken");

	range_refused_a: assert property (  // see R12
		wr && wb_adr_i == `RCO_CTRLSTS_OFF && wb_sel_i[0]
		&& wb_dat_i[`RCO_RANGE_MSB:`RCO_RANGE_LSB] == `RCO_RANGE_BAD
		|=> multispeed_osc_range_out == $past(st_reg.range))
		else $error("reserved range code reached the field");

	// bus side: one-cycle answer, and the data lines stay quiet between answers
	ack_answer_a: assert property (req |=> wb_ack_o)
		else $error("request not answered in one cycle");

	rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");

	// a byte lane left out of sel must not move the trim bits it holds
	trim_lane_a: assert property (  // see R10
		wr && wb_adr_i == `RCO_CTRLSTS_OFF && !wb_sel_i[2]
		|=> st_reg.trim[7:1] == $past(st_reg.trim[7:1]))
		else $error("trim changed through an unselected lane");

endmodule : rco_ctrl

`default_nettype wire

// ### verif/test_reset_cause_and_osc_control.sv
// self-checking testbench for the reset-cause and rc oscillator control block
`timescale 1ns/1ps
`default_nettype none
`include "rco_params.svh"

module test_reset_cause_and_osc_control;
	import rco_pkg::*;

	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic        clk, reset, cyc, stb, we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, dat_o, q;
	logic        ack, msi_stable, msi_clk, lsi_stable, lsi_clk, is_sys, irq;
	logic [2:0]  wake;   // deepest stop, standby, external oscillator fail
	logic [7:0]  ev;     // lpwr,wwdg,iwdg,sft,por,pin,mmu,ram
	logic [7:0]  fcal, cal_word, trim_m;
	logic [2:0]  range_o, range_m;
	logic [12:0] freq;
	logic        msi_en_o, lsi_en_o, multispeed_osc_enable_m, lowspeed_rc_enable_m, mrdy, lrdy;
	logic [7:0]  flg;
	logic [15:0] rnd;
	logic [3:0]  bsel;   // byte lanes the next bus cycle uses
	int          n_fail, compares;

	rco_ctrl u_dut (
		.clk(clk), .reset(reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.lowpower_mgmt_reset_evt(ev[7]), .windowed_watchdog_reset_evt(ev[6]),
		.independent_watchdog_reset_evt(ev[5]), .software_reset_evt(ev[4]),
		.power_on_reset_evt(ev[3]), .external_reset_pin_evt(ev[2]),
		.memory_mgmt_reset_evt(ev[1]), .ram_reset_evt(ev[0]),
		.multispeed_osc_stable(msi_stable), .multispeed_osc_clk(msi_clk),
		.multispeed_osc_factory_cal_in(fcal), .multispeed_osc_enable_out(msi_en_o),
		.multispeed_osc_cal_word(cal_word), .multispeed_osc_range_out(range_o),
		.multispeed_osc_freq_khz(freq), .lowspeed_rc_stable(lsi_stable),
		.lowspeed_rc_clk(lsi_clk), .lowspeed_rc_enable_out(lsi_en_o),
		.multispeed_is_sysclk(is_sys), .wake_from_deepest_stop_mode(wake[0]),
		.wake_from_standby(wake[1]), .external_highspeed_osc_fail(wake[2]), .irq(irq)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// 200 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [12:0] freq_of(input logic [2:0] r);
		logic [12:0] t [7];
		t = '{13'h0064, 13'h00C8, 13'h0190, 13'h0320, 13'h03E8, 13'h07D0, 13'h0FA0};
		return t[r];
	endfunction : freq_of

	// write image: read-only fields carry ones, which must be ignored
	function automatic logic [31:0] ctl(input logic clr);
		return {7'h7F, clr, 1'b1, trim_m, 8'hFF, range_m, 1'b1, multispeed_osc_enable_m, 1'b1, lowspeed_rc_enable_m};
	endfunction : ctl

	function automatic logic [31:0] exp_ctl(input logic [7:0] c);
		return {flg[7:1], 1'b0, flg[0], trim_m, c, range_m, mrdy, multispeed_osc_enable_m, lrdy, lowspeed_rc_enable_m};
	endfunction : exp_ctl

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one classic wishbone cycle; waits for ack without a bound, then checks two clocks
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= bsel;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("ack_latency", n, 32'h2);
	endtask : bus

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_clk

	// slow oscillator pulses, well apart so the synchroniser sees each edge
	task automatic osc(input logic lowspeed_rc_oscillator, input int n);
		repeat (n) begin
			@(posedge clk);
			if (lowspeed_rc_oscillator) lsi_clk <= 1'b1; else msi_clk <= 1'b1;
			wait_clk(4);
			if (lowspeed_rc_oscillator) lsi_clk <= 1'b0; else msi_clk <= 1'b0;
			wait_clk(4);
		end
	endtask : osc

	task automatic rd_ctl(input logic [7:0] c);
		bus(1'b0, 8'h24, 32'h0);
		chk("ctrlsts", q, exp_ctl(c));
	endtask : rd_ctl

	task automatic conclude;
		if (n_fail == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		wait_clk(20000);
		n_fail++;
		conclude();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{reset, cyc, stb, we, msi_clk, lsi_clk, is_sys} = 7'h40;
		{adr, sel, dat, ev, wake} = '0;
		bsel = 4'hF;
		{msi_stable, lsi_stable} = 2'h3;
		fcal = 8'h48;
		n_fail = 0;
		compares = 0;
		rnd = 16'h0022;
		{trim_m, range_m, multispeed_osc_enable_m, lowspeed_rc_enable_m, mrdy, lrdy, flg} = {8'h00, 3'h6, 4'hA, 8'h0C};
		wait_clk(6);
		reset <= 1'b0;
		wait_clk(10);
		rd_ctl(8'h48);
		chk("outs", {msi_en_o, lsi_en_o, irq, range_o, freq, cal_word},
			{3'h4, 3'h6, 13'h0FA0, 8'h48});
		// a zero in the clear bit leaves the flags alone, a one clears them all
		bus(1'b1, 8'h24, ctl(1'b0));
		rd_ctl(8'h48);
		bus(1'b1, 8'h24, ctl(1'b1));
		flg = 8'h00;
		rd_ctl(8'h48);
		// each cause alone sets its own flag, which stays after the cause goes
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			ev <= 8'h01 << i;
			wait_clk(3);
			ev <= 8'h00;
			wait_clk(4);
			flg = 8'h01 << i;
			rd_ctl(8'h48);
			bus(1'b1, 8'h24, ctl(1'b1));
			flg = 8'h00;
		end
		// every range code with a random trim
		for (int r = 0; r < 8; r++) begin
			rnd = lfsr(rnd);
			trim_m = rnd[7:0];
			range_m = r[2:0];
			bus(1'b1, 8'h24, ctl(1'b0));
			if (r == 7) range_m = 3'h6; // code 7 is refused, field keeps its value
			wait_clk(3);
			chk("freq", {range_o, freq}, {range_m, freq_of(range_m)});
			chk("cal_word", cal_word, 8'(trim_m + 8'h48));
			rd_ctl(8'h48);
		end
		// refused disable while the multispeed oscillator clocks the system
		bus(1'b1, 8'h40, 32'hF);
		is_sys <= 1'b1;
		wait_clk(4);
		multispeed_osc_enable_m = 1'b0;
		bus(1'b1, 8'h24, ctl(1'b0));
		multispeed_osc_enable_m = 1'b1;
		rd_ctl(8'h48);
		bus(1'b0, 8'h40, 32'h0);
		chk("irq_stat", q & 32'h8, 32'h8);
		chk("irq_masked", irq, 1'b0);
		bus(1'b1, 8'h44, 32'h8);
		wait_clk(3);
		chk("irq_on", irq, 1'b1);
		bus(1'b1, 8'h40, 32'h8);
		wait_clk(3);
		chk("irq_off", irq, 1'b0);
		is_sys <= 1'b0;
		wait_clk(4);
		// disable: ready holds through five oscillator edges, drops on the sixth
		multispeed_osc_enable_m = 1'b0;
		bus(1'b1, 8'h24, ctl(1'b0));
		osc(1'b0, 5);
		rd_ctl(8'h48);
		osc(1'b0, 1);
		mrdy = 1'b0;
		rd_ctl(8'h48);
		chk("msi_en_o", msi_en_o, 1'b0);
		// wake and oscillator failure each force the enable back on
		for (int s = 0; s < 3; s++) begin
			multispeed_osc_enable_m = 1'b0;
			if (s > 0) bus(1'b1, 8'h24, ctl(1'b0));
			bus(1'b1, 8'h40, 32'hF);
			@(posedge clk);
			wake <= 3'h1 << s;
			wait_clk(4);
			wake <= 3'h0;
			wait_clk(8);
			multispeed_osc_enable_m = 1'b1;
			mrdy = 1'b1;
			chk("forced", msi_en_o, 1'b1);
			rd_ctl(8'h48);
			bus(1'b0, 8'h40, 32'h0);
			chk("forced_ev", q & 32'h4, 32'h4);
		end
		// lowspeed oscillator: enable, ready, then three edges to drop
		lowspeed_rc_enable_m = 1'b1;
		bus(1'b1, 8'h24, ctl(1'b0));
		wait_clk(6);
		lrdy = 1'b1;
		rd_ctl(8'h48);
		chk("lsi_en_o", lsi_en_o, 1'b1);
		lowspeed_rc_enable_m = 1'b0;
		bus(1'b1, 8'h24, ctl(1'b0));
		osc(1'b1, 2);
		rd_ctl(8'h48);
		osc(1'b1, 1);
		lrdy = 1'b0;
		rd_ctl(8'h48);
		chk("lsi_off", lsi_en_o, 1'b0);
		// trim lanes only: range and enable byte must not move
		rnd = lfsr(rnd);
		trim_m = rnd[7:0];
		bsel = 4'h6;
		bus(1'b1, 8'h24, ctl(1'b0) ^ 32'h00000075);
		bsel = 4'hF;
		rd_ctl(8'h48);
		// unmapped address answers zero and ignores writes
		bus(1'b1, 8'h80, 32'hFFFFFFFF);
		bus(1'b0, 8'h80, 32'h0);
		chk("unmapped", q, 32'h0);
		rd_ctl(8'h48);
		// power-on reset in mid-run with a random factory value
		rnd = lfsr(rnd);
		@(posedge clk);
		fcal <= rnd[7:0];
		ev <= 8'h20;
		wait_clk(3);
		ev <= 8'h00;
		reset <= 1'b1;
		wait_clk(6);
		reset <= 1'b0;
		wait_clk(10);
		fcal <= ~rnd[7:0]; // later changes of the input must not reach the field
		{trim_m, range_m, multispeed_osc_enable_m, mrdy, flg} = {8'h00, 3'h6, 2'h3, 8'h0C};
		rd_ctl(rnd[7:0]);
		rnd = lfsr(rnd);
		trim_m = rnd[7:0];
		bus(1'b1, 8'h24, ctl(1'b0));
		wait_clk(3);
		chk("cal_word2", cal_word, 8'(trim_m + q[14:7]));
		rd_ctl(q[14:7]);
		conclude();
	end

endmodule : test_reset_cause_and_osc_control

`default_nettype wire
